/* rtl/codec_ctrl_pkg.sv */
// Constants, register layouts, carrier types and the format decode function of the codec control bank.
// Assumes a single core clock and a word-wide register port fed by the control port logic.
// Operation
// [R1] Two-bit field picks serial input: 00 input 3, 01 input 2, 10 input 1, 11 input 0.
// [R2] Word-clock polarity 0: left low, right high; 1 swaps the channels.
// [R3] Bit-clock polarity 0: data changes on falling edge; 1: on rising edge.
// [R4] Format 000 I2S, 001 left-justified, 011-110 right-justified 24/20/18/16, others reserved.
// [R5] One bit per analog input routes it to the ADC; input 1 chosen at reset.
// [R6] Each power bit 1 powers its block up; reset all zero, all down.
// [R7] Power bits: 15 PLL, 14 reference, 13 ADC, 12-9 DACs, ... 0 processor.
// [R8] Headphone control bit 7 set mutes the headphone amplifier; clear is normal.
// [R9] Five-bit attenuation in 1.5 dB steps, 0 dB to -46.5 dB.
// [R10] Read-only lock bit shows rate converter lock; writes to it do nothing.
// [R11] Master clock output enable bit turns the output pin on or off.
// [R12] Master clock select 001 gives 1024 fs, 1xx 128 fs, others reserved.
// [R13] PLL reference 64/128/256/512 fs for codes 00-11; enable bit uses or bypasses PLL.
// [R14] Clock register reads 0x1E00 after reset; bits 12 to 9 always read ones.
// [R15] Amplifier bit 4 at 0 enables chopping, at 1 disables it; 1 recommended.
// [R16] Software writes reserved bits as zero; device ignores them on write.
package codec_ctrl_pkg;

   localparam logic [15:0] ADDR_SRC_PORT = 16'h1056;
   localparam logic [15:0] ADDR_ADC_SEL = 16'h1057;
   localparam logic [15:0] ADDR_POWER = 16'h1058;
   localparam logic [15:0] ADDR_CLK_CTL = 16'h1059;
   localparam logic [15:0] ADDR_HP_CTL = 16'h105A;
   localparam logic [15:0] ADDR_AMP_CTL = 16'h110D;

   localparam logic [7:0] RST_SRC_PORT = 8'h00;
   localparam logic [15:0] RST_ADC_SEL = 16'h0001;
   localparam logic [15:0] RST_POWER = 16'h0000;
   localparam logic [15:0] RST_CLK_CTL = 16'h0000;
   localparam logic [15:0] RST_HP_CTL = 16'h0000;
   localparam logic [15:0] RST_AMP_CTL = 16'h0000;

   localparam logic [7:0] WMASK_SRC_PORT = 8'h7F;
   localparam logic [15:0] WMASK_ADC_SEL = 16'h000F;
   localparam logic [15:0] WMASK_POWER = 16'hFFFF;
   localparam logic [15:0] WMASK_CLK_CTL = 16'h017F;
   localparam logic [15:0] WMASK_HP_CTL = 16'h009F;
   localparam logic [15:0] WMASK_AMP_CTL = 16'h0010;
   localparam logic [15:0] CLK_FIXED_ONES = 16'h1E00;

   localparam int SRC_SEL_LSB = 5;
   localparam int SRC_LR_POS = 4;
   localparam int SRC_BCLK_POS = 3;
   localparam int SRC_FMT_LSB = 0;
   localparam int CLK_SRCMUX_POS = 8;
   localparam int CLK_LOCK_POS = 7;
   localparam int CLK_MCLKEN_POS = 6;
   localparam int CLK_MCLKSEL_LSB = 3;
   localparam int CLK_PLLSEL_LSB = 1;
   localparam int CLK_PLLEN_POS = 0;
   localparam int HP_MUTE_POS = 7;
   localparam int HP_ATTEN_LSB = 0;
   localparam int AMP_CHOP_POS = 4;
   localparam int PWR_PLL_POS = 15;
   localparam int PWR_REF_POS = 14;
   localparam int PWR_ADC_POS = 13;
   localparam int PWR_SRC_POS = 2;
   localparam int PWR_CPU_POS = 0;

   localparam logic [2:0] FMT_CODE_I2S = 3'h0;
   localparam logic [2:0] FMT_CODE_LEFT = 3'h1;
   localparam logic [2:0] FMT_CODE_RJ24 = 3'h3;
   localparam logic [2:0] FMT_CODE_RJ20 = 3'h4;
   localparam logic [2:0] FMT_CODE_RJ18 = 3'h5;
   localparam logic [2:0] FMT_CODE_RJ16 = 3'h6;
   localparam logic [2:0] MCLK_CODE_1024 = 3'h1;
   localparam logic [6:0] ATTEN_HALF_DB_STEP = 7'h03;

   typedef enum logic [2:0] {
      FMT_I2S, FMT_LEFT, FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16, FMT_RESERVED
   } src_format_e;

   typedef struct packed {
      logic [7:0] srcPort;
      logic [15:0] adcSel;
      logic [15:0] power;
      logic [15:0] clkCtl;
      logic [15:0] hpCtl;
      logic [15:0] ampCtl;
   } regs_s;

   typedef struct packed {
      logic [3:0] serialInSel;
      logic srcLeftHigh;
      logic srcDataOnRise;
      src_format_e srcFormat;
      logic srcFormatReserved;
      logic [3:0] analogInToAdc;
      logic [15:0] powerUp;
      logic srcMuxEnable;
      logic mclkOutEnable;
      logic mclkRatio1024;
      logic mclkRatio128;
      logic mclkSelReserved;
      logic [1:0] pllRefSel;
      logic pllEnable;
      logic hpMute;
      logic [4:0] hpAttenCode;
      logic [6:0] hpAttenHalfDb;
      logic dacAmpChopEnable;
   } ctrl_s;

   localparam regs_s REGS_RST = '{srcPort: RST_SRC_PORT, adcSel: RST_ADC_SEL,
      power: RST_POWER, clkCtl: RST_CLK_CTL, hpCtl: RST_HP_CTL, ampCtl: RST_AMP_CTL};

   function automatic src_format_e decode_format(input logic [2:0] code);
      src_format_e f;
      case (code)
         FMT_CODE_I2S: f = FMT_I2S;
         FMT_CODE_LEFT: f = FMT_LEFT;
         FMT_CODE_RJ24: f = FMT_RJ24;
         FMT_CODE_RJ20: f = FMT_RJ20;
         FMT_CODE_RJ18: f = FMT_RJ18;
         FMT_CODE_RJ16: f = FMT_RJ16;
         default: f = FMT_RESERVED;
      endcase
      return f;
   endfunction : decode_format

endpackage : codec_ctrl_pkg

/* rtl/codec_control_registers.sv */
// Control register bank of the codec: storage, readback and decoded control outputs.
// Assumes the control port logic presents word accesses on core_clk; lock comes in asynchronously.
`timescale 1ns/1ps
module codec_control_registers
   import codec_ctrl_pkg::*;
(
   input logic core_clk,
   input logic arst_n,
   input logic [15:0] regAddr,
   input logic regWrEn,
   input logic [15:0] regWrData,
   input logic regRdEn,
   input logic rateConvLocked,
   output logic [15:0] regRdData,
   output logic regRdValid,
   output ctrl_s ctrl
);

   typedef struct packed {
      regs_s regs;
      logic lockMeta;
      logic lockSync;
      logic [15:0] rdData;
      logic rdValid;
      ctrl_s ctrl;
   } state_s;

   // Turns stored register contents into the control levels the analog and clock blocks use.
   function automatic ctrl_s decode_ctrl(input regs_s r);
      ctrl_s c;
      logic [2:0] mSel;
      mSel = r.clkCtl[CLK_MCLKSEL_LSB +: 3];
      c = '0;
      c.serialInSel = 4'h8 >> r.srcPort[SRC_SEL_LSB +: 2]; // see [R1]
      c.srcLeftHigh = r.srcPort[SRC_LR_POS]; // see [R2]
      c.srcDataOnRise = r.srcPort[SRC_BCLK_POS]; // see [R3]
      c.srcFormat = decode_format(r.srcPort[SRC_FMT_LSB +: 3]); // see [R4]
      c.srcFormatReserved = (c.srcFormat == FMT_RESERVED); // see [R4]
      c.analogInToAdc = r.adcSel[3:0]; // see [R5]
      c.powerUp = r.power; // see [R6] see [R7]
      c.srcMuxEnable = r.clkCtl[CLK_SRCMUX_POS];
      c.mclkOutEnable = r.clkCtl[CLK_MCLKEN_POS]; // see [R11]
      c.mclkRatio1024 = (mSel == MCLK_CODE_1024); // see [R12]
      c.mclkRatio128 = mSel[2]; // see [R12]
      c.mclkSelReserved = !mSel[2] && (mSel != MCLK_CODE_1024); // see [R12]
      c.pllRefSel = r.clkCtl[CLK_PLLSEL_LSB +: 2]; // see [R13]
      c.pllEnable = r.clkCtl[CLK_PLLEN_POS]; // see [R13]
      c.hpMute = r.hpCtl[HP_MUTE_POS]; // see [R8]
      c.hpAttenCode = r.hpCtl[HP_ATTEN_LSB +: 5]; // see [R9]
      c.hpAttenHalfDb = 7'(c.hpAttenCode) * ATTEN_HALF_DB_STEP; // see [R9]
      c.dacAmpChopEnable = !r.ampCtl[AMP_CHOP_POS]; // see [R15]
      return c;
   endfunction : decode_ctrl

   // Stores only the defined bits of the addressed register; reserved bits are dropped.
   function automatic regs_s write_reg(input regs_s r, input logic [15:0] a,
                                       input logic [15:0] d);
      regs_s w;
      w = r;
      case (a)
         ADDR_SRC_PORT: w.srcPort = d[7:0] & WMASK_SRC_PORT; // see [R16]
         ADDR_ADC_SEL: w.adcSel = d & WMASK_ADC_SEL;
         ADDR_POWER: w.power = d & WMASK_POWER;
         ADDR_CLK_CTL: w.clkCtl = d & WMASK_CLK_CTL; // see [R10] see [R16]
         ADDR_HP_CTL: w.hpCtl = d & WMASK_HP_CTL;
         ADDR_AMP_CTL: w.ampCtl = d & WMASK_AMP_CTL;
         default: w = r;
      endcase
      return w;
   endfunction : write_reg

   // Returns the readback word; unmapped addresses read as zero.
   function automatic logic [15:0] read_reg(input regs_s r, input logic [15:0] a,
                                            input logic lock);
      logic [15:0] q;
      logic [15:0] lockBit;
      lockBit = '0;
      lockBit[CLK_LOCK_POS] = lock;
      case (a)
         ADDR_SRC_PORT: q = {8'h00, r.srcPort};
         ADDR_ADC_SEL: q = r.adcSel;
         ADDR_POWER: q = r.power;
         ADDR_CLK_CTL: q = r.clkCtl | CLK_FIXED_ONES | lockBit; // see [R10] see [R14]
         ADDR_HP_CTL: q = r.hpCtl;
         ADDR_AMP_CTL: q = r.ampCtl;
         default: q = 16'h0000;
      endcase
      return q;
   endfunction : read_reg

   localparam state_s STATE_RST = '{regs: REGS_RST, lockMeta: 1'b0, lockSync: 1'b0,
      rdData: 16'h0000, rdValid: 1'b0, ctrl: decode_ctrl(REGS_RST)};

   logic [1:0] rstSync_ff;
   logic rstN;
   state_s state_ff;
   state_s nxt_state;

   // Releases the asynchronous reset in step with the core clock.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync_ff <= 2'h0;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end

   assign rstN = rstSync_ff[1];

   always_comb begin
      nxt_state = state_ff;
      nxt_state.lockMeta = rateConvLocked;
      nxt_state.lockSync = state_ff.lockMeta;
      nxt_state.rdValid = 1'b0;
      if (regWrEn) begin
         nxt_state.regs = write_reg(state_ff.regs, regAddr, regWrData);
      end
      if (regRdEn) begin
         nxt_state.rdValid = 1'b1;
         nxt_state.rdData = read_reg(state_ff.regs, regAddr, state_ff.lockSync);
      end
      nxt_state.ctrl = decode_ctrl(nxt_state.regs);
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state_ff <= STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign regRdData = state_ff.rdData;
   assign regRdValid = state_ff.rdValid;
   assign ctrl = state_ff.ctrl;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstN);

   sequence wrTo(logic [15:0] a);
      regWrEn && (regAddr == a);
   endsequence

   sequence rdFrom(logic [15:0] a);
      regRdEn && (regAddr == a) && !regWrEn;
   endsequence

   chk_src_input_pick: assert property ( // see [R1]
      wrTo(ADDR_SRC_PORT) |=> ctrl.serialInSel[3 - $past(regWrData[6:5])] &&
         ($countones(ctrl.serialInSel) == 1))
      else $error("Serial input pick does not match the written select.");

   chk_src_polarity_bits: assert property ( // see [R2]
      wrTo(ADDR_SRC_PORT) |=> (ctrl.srcLeftHigh == $past(regWrData[4])) &&
         (ctrl.srcDataOnRise == $past(regWrData[3]))) // see [R3]
      else $error("Serial port polarity bits did not follow the write.");

   chk_src_format_code: assert property ( // see [R4]
      wrTo(ADDR_SRC_PORT) |=> ctrl.srcFormatReserved ==
         (($past(regWrData[2:0]) == 3'h2) || ($past(regWrData[2:0]) == 3'h7)))
      else $error("Reserved serial format code decoded wrongly.");

   chk_adc_route_write: assert property ( // see [R5]
      wrTo(ADDR_ADC_SEL) |=> ctrl.analogInToAdc == $past(regWrData[3:0]))
      else $error("Analog input routing did not follow the write.");

   chk_power_bits_map: assert property ( // see [R6]
      wrTo(ADDR_POWER) |=> (ctrl.powerUp[PWR_PLL_POS] == $past(regWrData[15])) &&
         (ctrl.powerUp[PWR_SRC_POS] == $past(regWrData[2])) &&
         (ctrl.powerUp[PWR_CPU_POS] == $past(regWrData[0]))) // see [R7]
      else $error("Power bit did not follow the write.");

   chk_hp_mute_write: assert property ( // see [R8]
      wrTo(ADDR_HP_CTL) |=> ctrl.hpMute == $past(regWrData[7]) ##1
         ($past(regWrEn) || $stable(ctrl.hpMute)))
      else $error("Headphone mute did not follow the write.");

   chk_hp_atten_steps: assert property ( // see [R9]
      wrTo(ADDR_HP_CTL) |=> ctrl.hpAttenHalfDb == 7'($past(regWrData[4:0])) * 7'h03)
      else $error("Headphone attenuation is not three half-decibels per code.");

   chk_lock_readback: assert property ( // see [R10]
      rdFrom(ADDR_CLK_CTL) |=> regRdValid && (regRdData[7] == $past(state_ff.lockSync)))
      else $error("Lock bit readback differs from the synchronised lock.");

   chk_mclk_pin_enable: assert property ( // see [R11]
      wrTo(ADDR_CLK_CTL) |=> ctrl.mclkOutEnable == $past(regWrData[6]))
      else $error("Master clock pin enable did not follow the write.");

   chk_mclk_ratio_pick: assert property ( // see [R12]
      wrTo(ADDR_CLK_CTL) |=> (ctrl.mclkRatio128 == $past(regWrData[5])) &&
         (ctrl.mclkRatio1024 == ($past(regWrData[5:3]) == 3'h1)))
      else $error("Master clock ratio decoded wrongly.");

   chk_pll_setup: assert property ( // see [R13]
      wrTo(ADDR_CLK_CTL) |=> (ctrl.pllRefSel == $past(regWrData[2:1])) &&
         (ctrl.pllEnable == $past(regWrData[0])))
      else $error("PLL setup did not follow the write.");

   chk_clk_fixed_ones: assert property ( // see [R14]
      rdFrom(ADDR_CLK_CTL) |=> (regRdData[12:9] == 4'hF) && (regRdData[15:13] == 3'h0))
      else $error("Clock register fixed bits read back wrongly.");

   chk_amp_chop_sense: assert property ( // see [R15]
      wrTo(ADDR_AMP_CTL) |=> ctrl.dacAmpChopEnable == !$past(regWrData[4]))
      else $error("Amplifier chopping sense is inverted.");

endmodule : codec_control_registers

/* test/ctrl_host.sv */
// Host controller model that makes word accesses on the register port of the bank.
// Assumes the bench calls one task at a time; idle lines show the inverse of the last value.
`timescale 1ns/1ps
module ctrl_host (
   input wire logic core_clk,
   output logic [15:0] regAddr,
   output logic regWrEn,
   output logic [15:0] regWrData,
   output logic regRdEn,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid
);
   initial begin
      regAddr = 16'h0000;
      regWrEn = 1'b0;
      regWrData = 16'h0000;
      regRdEn = 1'b0;
   end

   // Writes one word with a one-cycle strobe taken at the next rising edge.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge core_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask : wr

   // Reads one word; ok stays low when no valid pulse comes within a few cycles.
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
      int i;
      @(negedge core_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge core_clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      i = 0;
      while (regRdValid !== 1'b1 && i < 4) begin
         @(negedge core_clk);
         i++;
      end
      ok = (regRdValid === 1'b1);
      d = regRdData;
   endtask : rd
endmodule : ctrl_host

/* test/codec_control_registers_tb.sv */
// Self-checking bench of the codec control bank against a model of its registers.
// Assumes the host model drives the register port; this module drives reset and lock.
`timescale 1ns/1ps
module codec_control_registers_tb
   import codec_ctrl_pkg::*;
;
   localparam logic [15:0] ADR [6] = '{16'h1056, 16'h1057, 16'h1058, 16'h1059, 16'h105A, 16'h110D};
   localparam logic [15:0] MSK [6] = '{16'h007F, 16'h000F, 16'hFFFF, 16'h017F, 16'h009F, 16'h0010};
   logic core_clk, arst_n, regWrEn, regRdEn, rateConvLocked, regRdValid;
   logic [15:0] regAddr, regWrData, regRdData;
   ctrl_s ctrl;
   int n_fail, samples_checked, lockNow;
   int mdl [6];

   codec_control_registers uut (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .rateConvLocked(rateConvLocked), .regRdData(regRdData), .regRdValid(regRdValid),
      .ctrl(ctrl));
   ctrl_host host (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid));

   always #2 core_clk = ~core_clk;

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   function automatic ctrl_s expCtrl();
      ctrl_s c;
      logic [15:0] s, k, h;
      src_format_e fm [8];
      logic [3:0] pick [4];
      fm = '{FMT_I2S, FMT_LEFT, FMT_RESERVED, FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16,
         FMT_RESERVED};
      pick = '{4'h8, 4'h4, 4'h2, 4'h1};
      s = 16'(mdl[0]);
      k = 16'(mdl[3]);
      h = 16'(mdl[4]);
      c = '0;
      c.serialInSel = pick[s[6:5]];
      c.srcLeftHigh = s[4];
      c.srcDataOnRise = s[3];
      c.srcFormat = fm[s[2:0]];
      c.srcFormatReserved = (s[2:0] == 3'h2 || s[2:0] == 3'h7);
      c.analogInToAdc = 4'(mdl[1]);
      c.powerUp = 16'(mdl[2]);
      c.srcMuxEnable = k[8];
      c.mclkOutEnable = k[6];
      c.mclkRatio1024 = (k[5:3] == 3'h1);
      c.mclkRatio128 = k[5];
      c.mclkSelReserved = (k[5:3] == 3'h0 || k[5:3] == 3'h2 || k[5:3] == 3'h3);
      c.pllRefSel = k[2:1];
      c.pllEnable = k[0];
      c.hpMute = h[7];
      c.hpAttenCode = h[4:0];
      c.hpAttenHalfDb = 7'(h[4:0] * 3);
      c.dacAmpChopEnable = ~mdl[5][4];
      return c;
   endfunction : expCtrl

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t readback %h expected %h", $time, got, exp);
      end
   endtask : chk16

   task automatic chkCtrl();
      ctrl_s e;
      e = expCtrl();
      samples_checked++;
      if (ctrl !== e) begin
         n_fail++;
         $display("[ERR] %0t control outputs %h expected %h", $time, ctrl, e);
      end
   endtask : chkCtrl

   // Index 6 reads an unmapped address between two mapped ones.
   task automatic chkRd(input int i);
      logic [15:0] d, e;
      logic ok;
      host.rd((i < 6) ? ADR[i % 6] : 16'h105B, d, ok);
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t no read answer", $time);
         test_done();
      end
      e = (i < 6) ? 16'(mdl[i % 6]) : 16'h0000;
      if (i == 3) e = e | 16'h1E00 | (16'(lockNow) << 7);
      chk16(d, e);
   endtask : chkRd

   // Raw writes keep the given reserved bits so that the bank must ignore them.
   task automatic acc(input int i, input logic [15:0] d, input bit raw);
      if (!raw) d = d & MSK[i];
      host.wr(ADR[i], d);
      mdl[i] = int'(d & MSK[i]);
      chkCtrl();
      chkRd(i);
   endtask : acc

   task automatic doReset();
      arst_n = 1'b0;
      repeat (12) @(negedge core_clk);
      arst_n = 1'b1;
      mdl = '{0, 1, 0, 0, 0, 0};
      repeat (3) @(posedge core_clk);
      chkCtrl();
      for (int i = 0; i < 7; i++) chkRd(i);
      $display("Test reset values done");
   endtask : doReset

   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      rateConvLocked = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      lockNow = 0;
      void'($urandom(48882));
      doReset();
      for (int v = 0; v < 128; v++) acc(0, 16'(v), 1'b0);
      $display("Test serial port codes done");
      for (int v = 0; v < 128; v++) begin
         acc(3, {8'($urandom), 8'h80} | 16'(v), 1'b1);
      end
      $display("Test clock control done");
      for (int v = 0; v < 64; v++) begin
         acc(4, 16'((v & 31) | ((v & 32) << 2)), 1'b0);
      end
      for (int v = 0; v < 16; v++) acc(1, 16'(v), 1'b0);
      for (int b = 0; b < 16; b++) acc(2, 16'h0001 << b, 1'b0);
      acc(5, 16'h0010, 1'b0);
      acc(5, 16'h0000, 1'b0);
      $display("Test field codes done");
      for (int i = 0; i < 6; i++) acc(i, 16'hFFFF, 1'b1);
      host.wr(16'h105B, 16'($urandom));
      for (int i = 0; i < 7; i++) chkRd(i);
      $display("Test reserved and unmapped done");
      for (int l = 1; l >= 0; l--) begin
         rateConvLocked = l[0];
         lockNow = l;
         repeat (3) @(negedge core_clk);
         chkRd(3);
      end
      $display("Test lock status done");
      repeat (40) acc($urandom % 6, 16'($urandom), 1'b0);
      $display("Test random traffic done");
      doReset();
      test_done();
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      $display("[ERR] %0t run limit reached", $time);
      test_done();
   end
endmodule : codec_control_registers_tb
